// File: shared/fbc_defines.vh
`ifndef FBC_DEFINES_VH
`define FBC_DEFINES_VH
// ==========================================
// Response codes
`define FBC_RESP_OK 16'h0000
`define FBC_RESP_NO_WRITE 16'h0001
`define FBC_RESP_BAD_CMD 16'h0002
`define FBC_RESP_RANGE 16'h0003
// ==========================================
// Command word fields
`define FBC_GROUP_HI 12
`define FBC_GROUP_LO 8
`define FBC_DIR_BIT 7
`define FBC_GROUP_MAX 5'h11
`define FBC_NUM_MAX 7'h63
`define FBC_GROUP_COMM 5'h07
`define FBC_RO_NUM_A 7'h01
`define FBC_RO_NUM_B 7'h05
`define FBC_RO_NUM_C 7'h06
// ==========================================
// Reaction selector and secondary source values
`define FBC_SEL_COAST_NOW 4'h0
`define FBC_SEL_COAST_DLY 4'h1
`define FBC_SEL_COAST_RET 4'h2
`define FBC_SEL_KEEP 4'h3
`define FBC_SEL_DECEL_NOW 4'hA
`define FBC_SEL_DECEL_DLY 4'hB
`define FBC_SEL_DECEL_RET 4'hC
`define FBC_SEL_RUN_OFF 4'hD
`define FBC_SEL_FWD 4'hE
`define FBC_SEL_REV 4'hF
`define FBC_SEC_NONE 8'h03
// ==========================================
// Timing: delay tick of 0.1 s at 100 MHz
`define FBC_TICK_MS 100
`define FBC_CLK_KHZ 100000
`define FBC_TICK_CYCLES (`FBC_TICK_MS * `FBC_CLK_KHZ)
`endif

// File: logic/fbc_top.v
// Operation
// - Commands arrive in the command slot; responses go out in the response slot.
// - A command completing normally answers 0000 hex.
// - Write to run-locked or keypad-edited parameter answers 0001 hex.
// - An undecodable command word answers 0002 hex.
// - Write data outside the parameter range is rejected with 0003 hex.
// - Upper three bits zero; bits 12 to 8 carry group 00 to 11 hex.
// - Bit 7 selects read when zero, write when one.
// - Low seven bits carry parameter number 0 to 99.
// - Communication parameters 01, 05, 06 are read-only; writes answer 0001 hex.
// - Selector 0 or 4 to 9: coast immediately and raise link alarm.
// - Selector 1: wait delay, then coast and raise link alarm.
// - Selector 2: ignore fault if link returns in time, else coast and trip.
// - Selector 3: keep running, never raise link alarm.
// - Selector 10: decelerate now, raise alarm once motor has stopped.
// - Selector 11: wait delay, decelerate, raise alarm after stopping.
// - Selector 12: ignore if link returns in time, else decelerate and trip.
// - Selector 13: clear run command, no link alarm.
// - Selector 14 forces forward, 15 forces reverse, no link alarm.
// - Ignore link faults until the link was established once.
// - Ignore faults when neither run nor frequency source is the fieldbus.
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "fbc_defines.vh"
module fbc_top #(
  parameter TICK_CYCLES = `FBC_TICK_CYCLES
) (
  input wire clk_in,
  input wire nrst_in,
  input wire ce_in,
  input wire cmd_valid_in,
  input wire [15:0] cmd_word_in,
  input wire [15:0] cmd_wdata_in,
  input wire drive_running_in,
  input wire keypad_editing_in,
  input wire [7:0] param_attr_addr_unused_in,
  input wire param_run_locked_in,
  input wire param_in_range_in,
  input wire [15:0] param_rdata_in,
  input wire link_ok_in,
  input wire [3:0] link_fault_reaction_select_in,
  input wire [9:0] link_fault_delay_setting_in,
  input wire [7:0] bus_source_select_in,
  input wire [7:0] secondary_source_select_in,
  input wire link_enable_assigned_in,
  input wire link_enable_terminal_in,
  input wire motor_stopped_in,
  output reg [15:0] resp_code_out,
  output reg [15:0] resp_data_out,
  output reg resp_valid_out,
  output reg param_wr_out,
  output reg [4:0] param_group_out,
  output reg [6:0] param_num_out,
  output reg [15:0] param_wdata_out,
  output reg coast_stop_out,
  output reg decel_stop_out,
  output reg run_clear_out,
  output reg force_fwd_out,
  output reg force_rev_out,
  output reg link_error_alarm_out
);
  // ==========================================
  // Reset release and pin synchronisers
  // Pins are asynchronous to clk_in, so each passes two flip-flops and only
  // the second stage is read; reading the first could catch a metastable value.
  localparam PINS = 2;
  reg [1:0] rst_sync;
  wire rst_n = rst_sync[1];
  wire [PINS-1:0] pin_raw = {link_enable_terminal_in, link_ok_in};
  wire [PINS-1:0] pin_sync;
  wire link_ok = pin_sync[0];
  wire le_on = pin_sync[1];

  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end

  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi = gi + 1)
    begin : g_pin_sync
      reg [1:0] stages;
      always @(posedge clk_in or negedge rst_n)
      begin
        if (!rst_n)
        begin
          stages <= 2'b00;
        end
        else if (ce_in)
        begin
          stages <= {stages[0], pin_raw[gi]};
        end
      end
      assign pin_sync[gi] = stages[1];
    end
  endgenerate

  // ==========================================
  // Command decode
  wire [4:0] grp = cmd_word_in[`FBC_GROUP_HI:`FBC_GROUP_LO];
  wire [6:0] num = cmd_word_in[6:0];
  wire is_wr = cmd_word_in[`FBC_DIR_BIT];
  wire cmd_ok = (cmd_word_in[15:13] == 3'b000)
    && (grp <= `FBC_GROUP_MAX)
    && (num <= `FBC_NUM_MAX);
  reg ro_num;
  wire ro_param = (grp == `FBC_GROUP_COMM) && ro_num;

  // Only three numbers of the communication group refuse writes;
  // the rest of that group behaves like any other parameter.
  always @*
  begin
    ro_num = 1'b0;
    case (num)
      `FBC_RO_NUM_A:
        ro_num = 1'b1;
      `FBC_RO_NUM_B:
        ro_num = 1'b1;
      `FBC_RO_NUM_C:
        ro_num = 1'b1;
      default:
        ro_num = 1'b0;
    endcase
  end
  reg [15:0] next_code;

  always @*
  begin
    next_code = `FBC_RESP_OK;
    if (!cmd_ok)
      next_code = `FBC_RESP_BAD_CMD;
    else if (is_wr && ro_param)
      next_code = `FBC_RESP_NO_WRITE;
    else if (is_wr && ((param_run_locked_in && drive_running_in) || keypad_editing_in))
      next_code = `FBC_RESP_NO_WRITE;
    else if (is_wr && !param_in_range_in)
      next_code = `FBC_RESP_RANGE;
  end

  // Attribute inputs are combinational lookups on the same clock, so the
  // answer is ready one cycle after the command is taken.
  wire [15:0] next_rdata = (cmd_ok && !is_wr) ? param_rdata_in : 16'h0000;
  wire next_wr = is_wr && (next_code == `FBC_RESP_OK);

  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resp_code_out <= 16'h0000;
      resp_data_out <= 16'h0000;
      resp_valid_out <= 1'b0;
    end
    else if (ce_in)
    begin
      resp_valid_out <= cmd_valid_in;
      if (cmd_valid_in)
      begin
        resp_code_out <= next_code;
        resp_data_out <= next_rdata;
      end
    end
  end

  // ==========================================
  // Parameter port
  // The write strobe is one pulse; a refused write never reaches the
  // drive core, so a rejected value cannot land halfway.
  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      param_wr_out <= 1'b0;
      param_group_out <= 5'h00;
      param_num_out <= 7'h00;
      param_wdata_out <= 16'h0000;
    end
    else if (ce_in)
    begin
      param_wr_out <= cmd_valid_in && next_wr;
      if (cmd_valid_in)
      begin
        param_group_out <= grp;
        param_num_out <= num;
        param_wdata_out <= cmd_wdata_in;
      end
    end
  end

  // ==========================================
  // Link fault reaction
  localparam ST_IDLE = 3'd0;
  localparam ST_WAIT = 3'd1;
  localparam ST_COAST = 3'd2;
  localparam ST_DECEL = 3'd3;
  localparam ST_TRIP = 3'd4;
  localparam ST_HOLD = 3'd5;

  reg [2:0] state;
  reg [2:0] next_state;
  reg armed;
  reg [26:0] tick_cnt;
  reg [9:0] tenth_cnt;
  wire [3:0] sel = link_fault_reaction_select_in;
  wire bus_src = (bus_source_select_in != 8'h00)
    && !(link_enable_assigned_in && !le_on)
    && (secondary_source_select_in != `FBC_SEC_NONE)
    && (secondary_source_select_in != bus_source_select_in);
  wire fault = !link_ok && armed && bus_src;
  wire delayed = (sel == `FBC_SEL_COAST_DLY) || (sel == `FBC_SEL_COAST_RET)
    || (sel == `FBC_SEL_DECEL_DLY) || (sel == `FBC_SEL_DECEL_RET);
  wire retry = (sel == `FBC_SEL_COAST_RET) || (sel == `FBC_SEL_DECEL_RET);
  wire decel_mode = (sel == `FBC_SEL_DECEL_DLY) || (sel == `FBC_SEL_DECEL_RET);
  wire expired = (tenth_cnt >= link_fault_delay_setting_in);

  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (fault)
        begin
          if (sel == `FBC_SEL_KEEP)
            next_state = ST_IDLE;
          else if (sel == `FBC_SEL_DECEL_NOW)
            next_state = ST_DECEL;
          else if (delayed)
            next_state = ST_WAIT;
          else if (sel >= `FBC_SEL_RUN_OFF)
            next_state = ST_HOLD;
          else
            next_state = ST_COAST;
        end
      ST_WAIT:
        if (retry && link_ok)
          next_state = ST_IDLE;
        else if (expired)
          next_state = decel_mode ? ST_DECEL : ST_COAST;
      ST_COAST:
        next_state = ST_TRIP;
      ST_DECEL:
        if (motor_stopped_in)
          next_state = ST_TRIP;
      ST_TRIP:
        next_state = ST_TRIP;
      ST_HOLD:
        if (link_ok)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  // ==========================================
  // Reaction state and arming
  // Arming never falls back, so a link that came up once keeps the
  // reaction live until the card is reset.
  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      armed <= 1'b0;
    end
    else if (ce_in)
    begin
      state <= next_state;
      if (link_ok)
      begin
        armed <= 1'b1;
      end
    end
  end

  // ==========================================
  // Delay timer
  // Counting only in the wait state with the link down means a recovered
  // link always restarts the full delay, never a remainder.
  wire [31:0] tick_last = TICK_CYCLES - 1;
  wire tick_end = ({5'd0, tick_cnt} == tick_last);

  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_cnt <= 27'd0;
      tenth_cnt <= 10'd0;
    end
    else if (ce_in)
    begin
      if (state != ST_WAIT || link_ok)
      begin
        tick_cnt <= 27'd0;
        tenth_cnt <= 10'd0;
      end
      else if (tick_end)
      begin
        tick_cnt <= 27'd0;
        tenth_cnt <= tenth_cnt + 10'd1;
      end
      else
      begin
        tick_cnt <= tick_cnt + 27'd1;
      end
    end
  end

  // ==========================================
  // Reaction outputs
  reg next_coast;
  reg next_decel;
  reg next_run_clear;
  reg next_fwd;
  reg next_rev;
  reg next_alarm;

  // A trip keeps the stop style that led into it, so the drive core never
  // sees the stop mode flip under a latched alarm.
  always @*
  begin
    next_coast = 1'b0;
    next_decel = 1'b0;
    next_run_clear = 1'b0;
    next_fwd = 1'b0;
    next_rev = 1'b0;
    next_alarm = 1'b0;
    case (next_state)
      ST_COAST:
        next_coast = 1'b1;
      ST_DECEL:
        next_decel = 1'b1;
      ST_TRIP:
      begin
        next_coast = !decel_stop_out;
        next_decel = decel_stop_out;
        next_alarm = 1'b1;
      end
      ST_HOLD:
      begin
        next_run_clear = (sel == `FBC_SEL_RUN_OFF);
        next_fwd = (sel == `FBC_SEL_FWD);
        next_rev = (sel == `FBC_SEL_REV);
      end
      default:
        next_alarm = 1'b0;
    endcase
  end

  // Trip latches until reset; the alarm reset path lives in the drive core.
  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      coast_stop_out <= 1'b0;
      decel_stop_out <= 1'b0;
      run_clear_out <= 1'b0;
      force_fwd_out <= 1'b0;
      force_rev_out <= 1'b0;
      link_error_alarm_out <= 1'b0;
    end
    else if (ce_in)
    begin
      coast_stop_out <= next_coast;
      decel_stop_out <= next_decel;
      run_clear_out <= next_run_clear;
      force_fwd_out <= next_fwd;
      force_rev_out <= next_rev;
      link_error_alarm_out <= next_alarm;
    end
  end
endmodule // fbc_top
`default_nettype wire

// File: verification/fbc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module fbc_properties (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic cmd_valid_in,
  input wire logic [15:0] cmd_word_in,
  input wire logic drive_running_in,
  input wire logic keypad_editing_in,
  input wire logic param_run_locked_in,
  input wire logic param_in_range_in,
  input wire logic [7:0] bus_source_select_in,
  input wire logic [7:0] secondary_source_select_in,
  input wire logic [15:0] resp_code_out,
  input wire logic resp_valid_out,
  input wire logic param_wr_out,
  input wire logic coast_stop_out,
  input wire logic link_error_alarm_out
);
  // ==========================================
  // Command decode
  logic v, lg, w, ro, gw;
  assign v = cmd_valid_in & ce_in;
  assign lg = v & (cmd_word_in[15:13] == 3'h0) & (cmd_word_in[12:8] <= 5'h11)
    & (cmd_word_in[6:0] <= 7'h63);
  assign w = lg & cmd_word_in[7];
  assign ro = (cmd_word_in[12:8] == 5'h07) & (cmd_word_in[6:0] inside {7'h01, 7'h05, 7'h06});
  assign gw = w & !ro & !keypad_editing_in & !(param_run_locked_in & drive_running_in);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // ==========================================
  // Responses and link faults
  property p_resp; v |=> resp_valid_out; endproperty
  a_resp: assert property (p_resp) else $error("no response");
  property p_bad; v & !lg |=> resp_code_out == 16'h0002 && !param_wr_out; endproperty
  a_bad: assert property (p_bad) else $error("bad word");
  property p_rd; lg & !cmd_word_in[7] |=> resp_code_out == 16'h0000 && !param_wr_out; endproperty
  a_rd: assert property (p_rd) else $error("read");
  property p_ro; w & ro |=> resp_code_out == 16'h0001 && !param_wr_out; endproperty
  a_ro: assert property (p_ro) else $error("read-only write");
  property p_lk; w & !ro & !gw |=> resp_code_out == 16'h0001 && !param_wr_out; endproperty
  a_lk: assert property (p_lk) else $error("locked write");
  property p_rng; gw & !param_in_range_in |=> resp_code_out == 16'h0003 && !param_wr_out; endproperty
  a_rng: assert property (p_rng) else $error("range");
  property p_ok; gw & param_in_range_in |=> resp_code_out == 16'h0000 && param_wr_out; endproperty
  a_ok: assert property (p_ok) else $error("good write");
  property p_src; bus_source_select_in == 8'h00 || secondary_source_select_in == 8'h03
    |-> !coast_stop_out && !link_error_alarm_out; endproperty
  a_src: assert property (p_src) else $error("fault not ignored");
endmodule // fbc_properties
`default_nettype wire

// File: verification/fbc_master.sv
`timescale 1ns/1ps
`default_nettype none
module fbc_master (
  input wire logic clk_in,
  output logic cmd_valid_out,
  output logic [15:0] cmd_word_out,
  output logic [15:0] cmd_wdata_out
);
  initial {cmd_valid_out, cmd_word_out, cmd_wdata_out} = 33'h0;
  // ==========================================
  // Valid stays high across back-to-back sends
  task automatic send(input logic [15:0] wd, input logic [15:0] d);
    cmd_valid_out <= 1'b1;
    cmd_word_out <= wd;
    cmd_wdata_out <= d;
    @(posedge clk_in);
  endtask
  task automatic idle();
    cmd_valid_out <= 1'b0;
    cmd_word_out <= ~cmd_word_out;
  endtask
endmodule // fbc_master
`default_nettype wire

// File: verification/tb_fieldbus_param_cmd_and_link_fault.sv
`timescale 1ns/1ps
`default_nettype none
module tb_fieldbus_param_cmd_and_link_fault;
  logic clk_in = 1'b0, nrst_in = 1'b0, cmd_valid_in, drive_running_in = 1'b0;
  logic keypad_editing_in = 1'b0, param_run_locked_in = 1'b0, param_in_range_in = 1'b0;
  logic link_ok_in = 1'b1, resp_valid_out, param_wr_out, coast_stop_out, decel_stop_out;
  logic run_clear_out, force_fwd_out, force_rev_out, link_error_alarm_out;
  logic [15:0] cmd_word_in, cmd_wdata_in, resp_code_out, param_rdata_in = 16'h0000;
  logic [3:0] link_fault_reaction_select_in = 4'h3;
  logic [9:0] link_fault_delay_setting_in = 10'h000;
  logic [7:0] bus_source_select_in = 8'h01, secondary_source_select_in = 8'h00;
  logic [60:0] q[$];
  logic motor_stopped_in = 1'b1, link_enable_assigned_in = 1'b0, link_enable_terminal_in = 1'b0;
  logic [15:0] resp_data_out, param_wdata_out;
  logic [4:0] param_group_out;
  logic [6:0] param_num_out;
  int error_cnt = 0, n_compared = 0;
  // ==========================================
  // Word, run/lock/keypad/range, write pulse, code
  logic [31:0] cmds[17] = '{32'h045F1000, 32'h045FF000, 32'h01941100, 32'h01940003,
    32'h0194D001, 32'h01949100, 32'h01943001, 32'h07811001, 32'h07851001, 32'h07861001,
    32'h07821100, 32'h07011000, 32'h80001002, 32'h20001002, 32'h12001002, 32'h00641002,
    32'h11E31100};
  // Selector, source case, armed, delay, coast/decel/run-off/fwd/rev/alarm
  logic [23:0] lnks[17] = '{24'h001021, 24'h901021, 24'h101221, 24'h201221, 24'h301000,
    24'hA01011, 24'hB01111, 24'hC01111, 24'hD01008, 24'hE01004, 24'hF01002, 24'h011000,
    24'h021000, 24'h031000, 24'h041021, 24'h051000, 24'h000000};
  fbc_master u_fbc_master (.clk_in(clk_in), .cmd_valid_out(cmd_valid_in),
    .cmd_word_out(cmd_word_in), .cmd_wdata_out(cmd_wdata_in));
  fbc_top #(.TICK_CYCLES(4)) u_fbc_top (.ce_in(1'b1), .param_attr_addr_unused_in(8'h00), .*);
  initial forever #5 clk_in = ~clk_in;
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk_in)
    if (resp_valid_out === 1'b1)
      chk(64'({param_wr_out, resp_code_out, param_group_out, param_num_out, param_wdata_out,
        resp_data_out}), 64'(q.size() ? q.pop_front() : {61{1'b1}}));
  // Fresh reset per case, since the trip latches until reset
  task automatic link_case(input logic [23:0] e);
    nrst_in <= 1'b0;
    motor_stopped_in <= 1'b0;
    link_fault_reaction_select_in <= e[23:20];
    bus_source_select_in <= {7'h00, e[19:16] != 4'h1};
    secondary_source_select_in <= (e[19:16] == 4'h2) ? 8'h03 : (e[19:16] == 4'h5) ? 8'h01 : 8'h00;
    link_enable_assigned_in <= (e[19:16] == 4'h3) || (e[19:16] == 4'h4);
    link_enable_terminal_in <= (e[19:16] == 4'h4);
    link_ok_in <= e[15:12] == 4'h1;
    link_fault_delay_setting_in <= {6'h00, e[11:8]};
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    link_ok_in <= 1'b0;
    repeat (14) @(posedge clk_in);
    if (e[4])
      chk({58'h0, coast_stop_out, decel_stop_out, run_clear_out, force_fwd_out, force_rev_out,
        link_error_alarm_out}, 64'h10);
    motor_stopped_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk({58'h0, coast_stop_out, decel_stop_out, run_clear_out, force_fwd_out, force_rev_out,
      link_error_alarm_out}, {56'h0, e[7:0]});
  endtask
  initial
  begin
    #200000;
    error_cnt++;
    stop_test();
  end
  initial
  begin
    logic [15:0] rd, wd;
    void'($urandom(50));
    repeat (5) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    foreach (cmds[i])
    begin
      {drive_running_in, param_run_locked_in, keypad_editing_in, param_in_range_in} <= cmds[i][15:12];
      rd = 16'($urandom);
      wd = 16'($urandom);
      param_rdata_in <= rd;
      q.push_back({cmds[i][8], 8'h00, cmds[i][7:0], cmds[i][28:24], cmds[i][22:16], wd,
        (cmds[i][7:0] != 8'h02 && !cmds[i][23]) ? rd : 16'h0000});
      u_fbc_master.send(cmds[i][31:16], wd);
    end
    u_fbc_master.idle();
    repeat (3) @(posedge clk_in);
    chk(64'(q.size()), 64'h0);
    $display("Test command decode done");
    foreach (lnks[i])
      link_case(lnks[i]);
    $display("Test link reaction done");
    stop_test();
  end
endmodule // tb_fieldbus_param_cmd_and_link_fault
bind fbc_top fbc_properties u_fbc_properties (.*);
`default_nettype wire
